// ===== rtl/lan_host_dma_glue.sv
// Host-side glue between the LAN controller's tightly coupled DMA signals and the host bus.
// Assumes all inputs synchronous to clk; host DMA controller and CPU sit on the far side.
// Overview of operation
// (R1) Preamble collision: controller retries alone, no reinit
// (R2) Late collision without autoinit: interrupt, CPU retries
// (R3) No end-of-process input: never use autoinit
// (R4) Burst DMA limited to fifteen microseconds
// (R5) Decode interface, latch last received frame pointer
// (R6) Latch is 24 or 16 bits wide
// (R7) Alternative bus: drive 4-bit arbitration level
// (R8) Latch byte address on end-of-process at receive
// (R9) Collision with autoinit: request plus end-of-process
// (R10) Latch holds until next end-of-frame load
//
// Variants: ALT_BUS selects the wide latch and the arbitration drive.
// The standard build keeps the top byte of the pointer at zero.
// Without the hostHasEop strap autoinit is never used, because that host
// has no end-of-process input. Retry then falls back to the controller's
// own preamble retry, or to the interrupt that asks the CPU to retransmit.
// Limitation: the burst timer counts clock cycles, not time. BURST_CYC
// must be rescaled if the host clock differs from 100 MHz.
// Trade-off: the request drops for two cycles (rest, then idle) after a full burst.
// This costs a little bandwidth, but refresh always gets the bus in time.
`timescale 1ns/1ps
`default_nettype none
module lan_host_dma_glue #(
    parameter bit ALT_BUS = 1'b0,
    parameter int BURST_CYC = lan_glue_pkg::BURST_MAX_CYC,
    parameter logic [3:0] ARB_LEVEL = 4'h5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Strap: host DMA controller has an end-of-process input
    input wire logic hostHasEop,
    // Strap: controller is configured for automatic retry
    input wire logic autoRetryCfg,
    // Controller tightly coupled interface
    input wire logic lanDmaReq,
    input wire logic lanEop,
    input wire logic lanRxDir,
    input wire logic lanCollision,
    input wire logic lanInPreamble,
    // Host DMA side
    input wire logic hostDmaAck,
    input wire logic [23:0] hostDmaAddr,
    input wire logic arbGrant,
    output logic hostDmaReq,
    output logic hostEop,
    output logic [3:0] arbLevel,
    output logic arbDrive,
    output logic retryIrq,
    output logic lanRetryMode,
    output logic [23:0] rxFramePtr
);
    localparam int LW = ALT_BUS ? lan_glue_pkg::LATCH_W_ALT : lan_glue_pkg::LATCH_W_STD;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_BURST = 3'b010,
        S_REST = 3'b100
    } burst_t;

    typedef struct packed {
        burst_t st;
        logic [15:0] cnt;
        logic req;
        logic eop;
        logic irq;
        logic autoMode;
        logic retryMode;
        logic [3:0] arb;
        logic arbOn;
        logic [23:0] ptr;
    } state_t;

    state_t s_r, s_nxt;

    // Pointer masked to the variant's latch width
    function automatic logic [23:0] fitPtr(input logic [23:0] a);
        fitPtr = a & ((24'h1 << LW) - 24'h1);
    endfunction

    // Next state of all glue logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.eop = 1'b0;
        s_nxt.irq = 1'b0;
        // Autoinit only legal when the host can see end-of-process
        s_nxt.autoMode = hostHasEop; // R3
        // Retry mode pin is registered on its own so the output comes straight from a flop
        s_nxt.retryMode = !hostHasEop; // R1
        // Burst timer; request released for two cycles (rest and idle) to free the bus for refresh
        case (s_r.st)
            S_IDLE: begin
                s_nxt.cnt = '0;
                if (lanDmaReq) begin
                    s_nxt.st = S_BURST;
                end
            end
            S_BURST: begin
                s_nxt.cnt = s_r.cnt + 16'h1;
                if (!lanDmaReq) begin
                    s_nxt.st = S_IDLE;
                end else if (s_r.cnt >= 16'(BURST_CYC - 2)) begin
                    s_nxt.st = S_REST; // R4
                end
            end
            S_REST: begin
                s_nxt.st = S_IDLE;
            end
            default: s_nxt.st = S_IDLE;
        endcase
        s_nxt.req = lanDmaReq && (s_nxt.st == S_BURST); // R4
        // Arbitration level drive on the alternative bus
        s_nxt.arb = ALT_BUS ? ARB_LEVEL : 4'h0; // R7
        s_nxt.arbOn = ALT_BUS && s_nxt.req && !arbGrant; // R7
        // Receive end: latch the address of the byte count high byte
        if (lanEop && lanRxDir && hostDmaAck) begin
            s_nxt.ptr = fitPtr(hostDmaAddr); // R5 R6 R8
            s_nxt.eop = 1'b1; // R8
        end
        // Collision handling; pointer is untouched here so it stays stable
        if (lanCollision && !lanRxDir) begin
            if (s_r.autoMode) begin
                s_nxt.req = 1'b1; // R9
                s_nxt.eop = 1'b1; // R9
            end else if (!(lanInPreamble && autoRetryCfg)) begin
                s_nxt.irq = 1'b1; // R2
            end
            // Preamble collision with autoRetryCfg and no autoinit needs no host action at all; R1
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Reset leaves the controller in its safe retry mode until straps are seen
            s_r <= '{st: S_IDLE,
                     cnt: '0,
                     req: 1'b0,
                     eop: 1'b0,
                     irq: 1'b0,
                     autoMode: 1'b0,
                     retryMode: 1'b1,
                     arb: 4'h0,
                     arbOn: 1'b0,
                     ptr: '0};
        end else begin
            s_r <= s_nxt; // R10
        end
    end

    assign hostDmaReq = s_r.req;
    assign hostEop = s_r.eop;
    assign retryIrq = s_r.irq;
    assign lanRetryMode = s_r.retryMode; // R1
    assign arbLevel = s_r.arb;
    assign arbDrive = s_r.arbOn;
    assign rxFramePtr = s_r.ptr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_burst_limit: assert property (s_r.cnt <= 16'(BURST_CYC)) // R4
        else $error("burst exceeded limit");
    a_ptr_load: assert property (lanEop && lanRxDir && hostDmaAck |=> rxFramePtr == fitPtr($past(hostDmaAddr))) // R8
        else $error("pointer not latched");
    a_ptr_hold: assert property (!(lanEop && lanRxDir && hostDmaAck) |=> $stable(rxFramePtr)) // R10
        else $error("pointer changed without load");
    a_late_irq: assert property (lanCollision && !lanRxDir && !hostHasEop && !s_r.autoMode && !lanInPreamble
        |=> retryIrq) // R2
        else $error("late collision gave no interrupt");
    a_pre_quiet: assert property (lanCollision && !lanRxDir && !s_r.autoMode && lanInPreamble && autoRetryCfg
        && !(lanEop && lanRxDir) |=> !retryIrq && !hostEop) // R1
        else $error("preamble collision disturbed host");
    a_autoinit_pair: assert property (lanCollision && !lanRxDir && s_r.autoMode |=> hostDmaReq && hostEop) // R9
        else $error("autoinit pair missing");
    a_no_autoinit: assert property (!hostHasEop ##1 !hostHasEop |-> !s_r.autoMode) // R3
        else $error("autoinit used without input");
    a_ptr_width: assert property (ALT_BUS || rxFramePtr[23:16] == 8'h00) // R6
        else $error("pointer wider than latch");
    a_arb_level: assert property (arbDrive |-> arbLevel == ARB_LEVEL && ALT_BUS) // R7
        else $error("wrong arbitration level");
    a_ptr_decode: assert property (rxFramePtr != $past(rxFramePtr) |-> $past(lanEop && lanRxDir)) // R5
        else $error("pointer loaded without decode");

    // The rest cycle must really free the bus, unless a collision forced a request
    a_rest_gap: assert property (s_r.st == S_REST && !$past(lanCollision) |-> !hostDmaReq) // R4
        else $error("request held through rest cycle");
    // Without a controller request or collision the host request falls
    a_req_follow: assert property (!lanDmaReq && !lanCollision |=> !hostDmaReq) // R4
        else $error("request without cause");
    // End-of-process only for a receive end or an autoinit collision
    a_eop_cause: assert property (hostEop |-> $past(lanEop && lanRxDir && hostDmaAck)
        || $past(lanCollision && !lanRxDir && s_r.autoMode)) // R8
        else $error("end-of-process without cause");
    // Interrupt only for a transmit collision when autoinit is unusable
    a_irq_cause: assert property (retryIrq |-> $past(lanCollision && !lanRxDir && !s_r.autoMode)) // R2
        else $error("interrupt without cause");
    // Retry mode pin follows the inverted strap one cycle later
    a_retry_mode: assert property (1'b1 |=> lanRetryMode == !$past(hostHasEop)) // R3
        else $error("retry mode does not follow strap");
    // Once granted the level is no longer driven
    a_arb_drop: assert property (arbGrant |=> !arbDrive) // R7
        else $error("arbitration drive after grant");

    c_burst_cut: cover property (s_r.st == S_BURST ##1 s_r.st == S_REST);
    c_rx_load: cover property (lanEop && lanRxDir && hostDmaAck);
    c_irq: cover property (retryIrq);
    c_autoinit: cover property (hostEop && hostDmaReq && !s_r.ptr[0]);
    c_pre_quiet: cover property (lanCollision && !lanRxDir && lanInPreamble && autoRetryCfg && !s_r.autoMode);
endmodule
`default_nettype wire

// ===== rtl/lan_glue_pkg.sv
// Package for the LAN host DMA glue: widths, timing and the retry mode set.
// Assumes a single 100 MHz host-side clock.
package lan_glue_pkg;
    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 10000;
    // Longest burst in nanoseconds, and its cycle count (rounded down)
    localparam int BURST_MAX_NS = 15000;
    localparam int BURST_MAX_CYC = (BURST_MAX_NS * 1000) / CLK_PERIOD_PS;
    // Latch widths for the two bus variants
    localparam int LATCH_W_STD = 16;
    localparam int LATCH_W_ALT = 24;
    // Arbitration level width on the alternative bus
    localparam int ARB_W = 4;
    // Retry methods
    typedef enum logic [1:0] {
        RETRY_AUTOINIT = 2'h0,
        RETRY_PREAMBLE = 2'h1,
        RETRY_IRQ = 2'h2
    } retry_t;
endpackage

// ===== verif/host_dma_model.sv
// Host DMA controller model: acks requests and walks a byte address.
// Assumes the bench clock and active-low reset.
`timescale 1ns/1ps
`default_nettype none
module host_dma_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request in, pace select
    input wire logic hostDmaReq,
    input wire logic slow,
    // Acknowledge and address out
    output logic hostDmaAck,
    output logic [23:0] hostDmaAddr
);
    logic [23:0] addr_r;
    logic tick_r;
    // Slow pace acks every other cycle; start below 64k so the walk crosses it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hostDmaAck <= 1'b0;
            addr_r <= 24'h00fff0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= !tick_r;
            hostDmaAck <= hostDmaReq && (!slow || tick_r);
            addr_r <= addr_r + 24'(hostDmaAck);
        end
    end
    // Idle address is inverted rather than held, so a stale read shows
    assign hostDmaAddr = hostDmaAck ? addr_r : ~addr_r;
endmodule
`default_nettype wire

// ===== verif/test_lan_host_dma_glue.sv
// Self-checking bench for the LAN host DMA glue, alternative bus build.
// Assumes host_dma_model on the far side.
`timescale 1ns/1ps
`default_nettype none
module test_lan_host_dma_glue;
    logic clk = 1'b0, resetn = 1'b0, hostHasEop = 1'b1, autoRetryCfg = 1'b0, lanDmaReq = 1'b0;
    logic lanEop = 1'b0, lanRxDir = 1'b0, lanCollision = 1'b0, lanInPreamble = 1'b0, arbGrant = 1'b0;
    logic slow = 1'b0, hostDmaReq, hostEop, arbDrive, retryIrq, lanRetryMode, hostDmaAck, ld = 1'b0;
    logic [3:0] arbLevel;
    logic gPrev = 1'b0;
    logic [23:0] rxFramePtr, hostDmaAddr, expPtr = 24'h0;
    logic [31:0] seed = 32'hc0058a5e;
    int failures = 0, num_checks = 0, cnt = 0, full = 0;
    lan_host_dma_glue #(.ALT_BUS(1'b1), .BURST_CYC(20)) lan_host_dma_glue_i (.clk(clk), .resetn(resetn),
        .hostHasEop(hostHasEop), .autoRetryCfg(autoRetryCfg), .lanDmaReq(lanDmaReq), .lanEop(lanEop),
        .lanRxDir(lanRxDir), .lanCollision(lanCollision), .lanInPreamble(lanInPreamble),
        .hostDmaAck(hostDmaAck), .hostDmaAddr(hostDmaAddr), .arbGrant(arbGrant), .hostDmaReq(hostDmaReq),
        .hostEop(hostEop), .arbLevel(arbLevel), .arbDrive(arbDrive), .retryIrq(retryIrq),
        .lanRetryMode(lanRetryMode), .rxFramePtr(rxFramePtr));
    host_dma_model host_dma_model_i (.clk(clk), .resetn(resetn), .hostDmaReq(hostDmaReq), .slow(slow),
        .hostDmaAck(hostDmaAck), .hostDmaAddr(hostDmaAddr));
    // Clock
    always #5 clk = !clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One collision; exp is {hostDmaReq, hostEop, retryIrq} a cycle later
    task automatic hit(input logic cfg, input logic pre, input logic [2:0] exp);
        @(posedge clk);
        autoRetryCfg <= cfg;
        lanCollision <= 1'b1;
        lanInPreamble <= pre;
        @(posedge clk);
        lanCollision <= 1'b0;
        #1 chk(24'(exp), 24'({hostDmaReq, hostEop, retryIrq}));
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        chk(24'(lanRetryMode), 24'h1);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk(24'(lanRetryMode), 24'h0);
        hit(1'b0, 1'b0, 3'h6);
        hostHasEop <= 1'b0;
        hit(1'b0, 1'b0, 3'h1);
        chk(24'(lanRetryMode), 24'h1);
        hit(1'b1, 1'b1, 3'h0);
        $display("collision tests done");
        // Random frame ends, back to back, with fast and slow acks
        for (int i = 0; i < 300; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            lanEop <= seed[0];
            lanRxDir <= 1'b1;
            lanDmaReq <= 1'b1;
            slow <= seed[4];
            arbGrant <= seed[6];
            #1 chk(rxFramePtr, expPtr);
            chk(24'(hostEop), 24'(ld));
            chk(24'(arbLevel), 24'h5);
            chk(24'(arbDrive), 24'(hostDmaReq && !gPrev));
            gPrev = seed[6];
            ld = lanEop && hostDmaAck;
            if (ld) expPtr = hostDmaAddr;
            cnt = hostDmaReq ? cnt + 1 : 0;
            chk(24'(cnt > 19), 24'h0);
            if (cnt == 19) full++;
        end
        chk(24'(full != 0), 24'h1);
        $display("receive and burst tests done");
        print_verdict();
    end
    // Watchdog: the run needs about 3.2 us, so 100 us means a hang
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
